// *** inc/ump_pkg.sv ***
package ump_pkg;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  // ==========================================================
  // Register offsets
  // ==========================================================
  localparam logic [ADDR_W-1:0] OFS_MODEM_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_MODEM_STAT = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT   = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK   = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_TX_TRIG    = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_RTS_HALT   = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_RTS_RESUME = 3'h6;
  localparam logic [ADDR_W-1:0] OFS_PIN_STAT   = 3'h7;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int unsigned MCR_RTS_BIT      = 1;
  localparam int unsigned MCR_LOOP_BIT     = 4;
  localparam int unsigned MCR_AUTO_RTS_BIT = 5;
  localparam int unsigned MSR_TRAIL_BIT    = 2;
  localparam int unsigned MSR_RING_BIT     = 6;
  localparam int unsigned EV_RING_BIT      = 0;
  localparam int unsigned EV_RX_RDY_BIT    = 1;
  localparam int unsigned EV_TX_RDY_BIT    = 2;
  localparam int unsigned PIN_RX_RDY_BIT   = 0;
  localparam int unsigned PIN_TX_RDY_BIT   = 1;
  localparam int unsigned PIN_RTS_BIT      = 2;
  localparam int unsigned EV_W             = 3;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [DATA_W-1:0] RST_MODEM_CTRL = 8'h00;
  localparam logic [EV_W-1:0]   RST_INT_MASK   = 3'h0;
  localparam logic [DATA_W-1:0] RST_TX_TRIG    = 8'h10;
  localparam logic [DATA_W-1:0] RST_RTS_HALT   = 8'h60;
  localparam logic [DATA_W-1:0] RST_RTS_RESUME = 8'h20;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ump_bus_req_t;

  typedef struct packed {
    logic              trig_reached;
    logic              timeout;
    logic              fifo_empty;
    logic              fifo_err;
    logic [DATA_W-1:0] level;
  } ump_rx_stat_t;

  typedef struct packed {
    logic              full;
    logic [DATA_W-1:0] free_cnt;
  } ump_tx_stat_t;

endpackage

// *** design/ump_modem_pins.sv ***
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - Status bit 6 shows the present ring indicator level on every read.
// - Status bit 2 flags a low-to-high ring change since the last status read.
// - That ring change raises the interrupt when its mask bit enables it.
// - Request-to-send active with control bit 1; inactive on reset, loop, or clear.
// - Automatic mode lets receive level thresholds force request-to-send inactive.
// - Loopback ignores the receive pin and feeds transmit data to the receiver.
// - Loopback holds the transmit pin idle while data loops internally.
// - Receive-ready goes low on trigger level reached or receive timeout.
// - Receive-ready returns high when the receive buffer empties or holds an error.
// - Transmit-ready goes low once free space reaches the trigger count.
// - Transmit-ready goes high when the transmit buffer is full.
// - The interrupt drops once serviced, or on reset.
module ump_modem_pins
  import ump_pkg::*;
#(
  parameter int unsigned P_DATA_W = DATA_W
)
(
  // Clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  // Register port
  input  wire ump_bus_req_t      i_bus,
  output logic [P_DATA_W-1:0]    o_rd_data,
  // Modem side pins
  input  wire logic              i_ring_indicator_in,
  input  wire logic              i_rx_pin,
  output logic                   o_tx_pin,
  output logic                   o_rts_n,
  // Internal serial data paths
  input  wire logic              i_tx_serial,
  output logic                   o_rx_serial,
  // Buffer status from the data path
  input  wire ump_rx_stat_t      i_rx_stat,
  input  wire ump_tx_stat_t      i_tx_stat,
  // Ready and interrupt outputs
  output logic                   o_rx_ready_n,
  output logic                   o_tx_ready_n,
  output logic                   o_irq
);

  // ==========================================================
  // Register decode
  // ==========================================================
  logic [DATA_W-1:0] modem_control_reg_r;
  logic [EV_W-1:0]   int_stat_r;
  logic [EV_W-1:0]   int_stat_nxt;
  logic [EV_W-1:0]   int_mask_r;
  logic [DATA_W-1:0] tx_trig_r;
  logic [DATA_W-1:0] rts_halt_r;
  logic [DATA_W-1:0] rts_resume_r;
  logic              ring_prev_r;
  logic              ring_trailing_edge_flag_r;
  logic              rts_hold_r;
  logic              rx_ready_n_r;
  logic              tx_ready_n_r;
  logic              ring_rise;
  logic              rx_rdy_fall;
  logic              tx_rdy_fall;
  logic              rx_ready_n_nxt;
  logic              tx_ready_n_nxt;
  logic              loop_mode;
  logic              auto_rts;
  logic              rts_active;
  logic              stat_read;
  logic [DATA_W-1:0] rd_mux;

  function automatic logic wr_hit(input ump_bus_req_t req, input logic [ADDR_W-1:0] ofs);
    wr_hit = req.wr && (req.addr == ofs);
  endfunction

  function automatic logic rd_hit(input ump_bus_req_t req, input logic [ADDR_W-1:0] ofs);
    rd_hit = req.rd && (req.addr == ofs);
  endfunction

  assign loop_mode = modem_control_reg_r[MCR_LOOP_BIT];
  assign auto_rts  = modem_control_reg_r[MCR_AUTO_RTS_BIT];
  assign stat_read = rd_hit(i_bus, OFS_MODEM_STAT);

  // ==========================================================
  // Software registers
  // ==========================================================
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      modem_control_reg_r <= RST_MODEM_CTRL;
    end
    else if (wr_hit(i_bus, OFS_MODEM_CTRL))
    begin
      modem_control_reg_r <= i_bus.wdata;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      int_mask_r <= RST_INT_MASK;
    end
    else if (wr_hit(i_bus, OFS_INT_MASK))
    begin
      int_mask_r <= i_bus.wdata[EV_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tx_trig_r    <= RST_TX_TRIG;
      rts_halt_r   <= RST_RTS_HALT;
      rts_resume_r <= RST_RTS_RESUME;
    end
    else
    begin
      if (wr_hit(i_bus, OFS_TX_TRIG))
      begin
        tx_trig_r <= i_bus.wdata;
      end
      if (wr_hit(i_bus, OFS_RTS_HALT))
      begin
        rts_halt_r <= i_bus.wdata;
      end
      if (wr_hit(i_bus, OFS_RTS_RESUME))
      begin
        rts_resume_r <= i_bus.wdata;
      end
    end
  end

  // ==========================================================
  // Ring indicator
  // ==========================================================
  // The pin is taken as synchronous, so one stage of history is enough.
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ring_prev_r <= 1'b0;
    end
    else
    begin
      ring_prev_r <= i_ring_indicator_in;
    end
  end

  assign ring_rise = !ring_prev_r && i_ring_indicator_in;

  // trailing edge flag
  // A rise in the very cycle of the status read is kept for the next read.
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ring_trailing_edge_flag_r <= 1'b0;
    end
    else if (ring_rise)
    begin
      ring_trailing_edge_flag_r <= 1'b1;
    end
    else if (stat_read)
    begin
      ring_trailing_edge_flag_r <= 1'b0;
    end
  end

  // ==========================================================
  // Request to send
  // ==========================================================
  // threshold hold logic
  // Two thresholds give hysteresis so the pin does not chatter near one level.
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rts_hold_r <= 1'b0;
    end
    else if (i_rx_stat.level >= rts_halt_r)
    begin
      rts_hold_r <= 1'b1;
    end
    else if (i_rx_stat.level <= rts_resume_r)
    begin
      rts_hold_r <= 1'b0;
    end
  end

  assign rts_active = modem_control_reg_r[MCR_RTS_BIT] && !loop_mode
                      && !(auto_rts && rts_hold_r);

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rts_n <= 1'b1;
    end
    else
    begin
      o_rts_n <= !rts_active;
    end
  end

  // ==========================================================
  // Loopback routing
  // ==========================================================
  // receive path select
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rx_serial <= 1'b1;
    end
    else
    begin
      o_rx_serial <= loop_mode ? i_tx_serial : i_rx_pin;
    end
  end

  // transmit pin idle
  // The pin rests at the marking level rather than floating in loopback.
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_tx_pin <= 1'b1;
    end
    else
    begin
      o_tx_pin <= loop_mode ? 1'b1 : i_tx_serial;
    end
  end

  // ==========================================================
  // Ready outputs
  // ==========================================================
  // receive ready low
  // receive ready high
  // Empty or error wins over the set terms: the data path must not be drained.
  always_comb
  begin
    rx_ready_n_nxt = rx_ready_n_r;
    if (i_rx_stat.fifo_empty || i_rx_stat.fifo_err)
    begin
      rx_ready_n_nxt = 1'b1;
    end
    else if (i_rx_stat.trig_reached || i_rx_stat.timeout)
    begin
      rx_ready_n_nxt = 1'b0;
    end
  end

  always_comb
  begin
    tx_ready_n_nxt = tx_ready_n_r;
    if (i_tx_stat.full)
    begin
      tx_ready_n_nxt = 1'b1;
    end
    else if (i_tx_stat.free_cnt >= tx_trig_r)
    begin
      tx_ready_n_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rx_ready_n_r <= 1'b1;
      tx_ready_n_r <= 1'b1;
    end
    else
    begin
      rx_ready_n_r <= rx_ready_n_nxt;
      tx_ready_n_r <= tx_ready_n_nxt;
    end
  end

  assign o_rx_ready_n = rx_ready_n_r;
  assign o_tx_ready_n = tx_ready_n_r;
  assign rx_rdy_fall  = rx_ready_n_r && !rx_ready_n_nxt;
  assign tx_rdy_fall  = tx_ready_n_r && !tx_ready_n_nxt;

  // ==========================================================
  // Interrupt status and output
  // ==========================================================
  // write-one service
  // New events win over a clear written in the same cycle.
  always_comb
  begin
    int_stat_nxt = int_stat_r;
    if (wr_hit(i_bus, OFS_INT_STAT))
    begin
      int_stat_nxt = int_stat_r & ~i_bus.wdata[EV_W-1:0];
    end
    if (ring_rise)
    begin
      int_stat_nxt[EV_RING_BIT] = 1'b1;
    end
    if (rx_rdy_fall)
    begin
      int_stat_nxt[EV_RX_RDY_BIT] = 1'b1;
    end
    if (tx_rdy_fall)
    begin
      int_stat_nxt[EV_TX_RDY_BIT] = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      int_stat_r <= '0;
    end
    else
    begin
      int_stat_r <= int_stat_nxt;
    end
  end

  // masked interrupt
  // Built from the next status so the output flop tracks the status flop.
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_irq <= 1'b0;
    end
    else
    begin
      o_irq <= |(int_stat_nxt & int_mask_r);
    end
  end

  // ==========================================================
  // Read port
  // ==========================================================
  always_comb
  begin
    rd_mux = '0;
    case (i_bus.addr)
      OFS_MODEM_CTRL:
      begin
        rd_mux = modem_control_reg_r;
      end
      OFS_MODEM_STAT:
      begin
        rd_mux[MSR_RING_BIT]  = i_ring_indicator_in;
        rd_mux[MSR_TRAIL_BIT] = ring_trailing_edge_flag_r;
      end
      OFS_INT_STAT:
      begin
        rd_mux[EV_W-1:0] = int_stat_r;
      end
      OFS_INT_MASK:
      begin
        rd_mux[EV_W-1:0] = int_mask_r;
      end
      OFS_TX_TRIG:
      begin
        rd_mux = tx_trig_r;
      end
      OFS_RTS_HALT:
      begin
        rd_mux = rts_halt_r;
      end
      OFS_RTS_RESUME:
      begin
        rd_mux = rts_resume_r;
      end
      OFS_PIN_STAT:
      begin
        rd_mux[PIN_RX_RDY_BIT] = rx_ready_n_r;
        rd_mux[PIN_TX_RDY_BIT] = tx_ready_n_r;
        rd_mux[PIN_RTS_BIT]    = o_rts_n;
      end
      default:
      begin
        rd_mux = '0;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe and is zero otherwise.
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rd_data <= '0;
    end
    else if (i_bus.rd)
    begin
      o_rd_data <= rd_mux;
    end
    else
    begin
      o_rd_data <= '0;
    end
  end

endmodule

// *** bench/ump_modem_pins_monitor.sv ***
`timescale 1ns/1ps
module ump_modem_pins_monitor
  import ump_pkg::*;
#(
  parameter int unsigned P_DATA_W = DATA_W
)
(
  // Clock and reset
  input wire logic                i_core_clk,
  input wire logic                i_rst,
  // Register port
  input wire ump_bus_req_t        i_bus,
  input wire logic [P_DATA_W-1:0] o_rd_data,
  // Modem side
  input wire logic                i_ring_indicator_in,
  input wire logic                i_rx_pin,
  input wire logic                o_tx_pin,
  input wire logic                o_rts_n,
  input wire logic                i_tx_serial,
  input wire logic                o_rx_serial,
  // Status and ready
  input wire ump_rx_stat_t        i_rx_stat,
  input wire ump_tx_stat_t        i_tx_stat,
  input wire logic                o_rx_ready_n,
  input wire logic                o_tx_ready_n,
  input wire logic                o_irq
);
  // ======
  // Register mirror
  // ======
  // Mirrors only what software writes; status side stays in the design.
  logic [DATA_W-1:0] mcr_r, mask_r, trig_r, halt_r;
  logic              msr_rd;
  assign msr_rd = i_bus.rd && (i_bus.addr == OFS_MODEM_STAT);
  always_ff @(posedge i_core_clk or posedge i_rst)
    if (i_rst)
    begin
      mcr_r  <= RST_MODEM_CTRL;
      mask_r <= 8'h00;
      trig_r <= RST_TX_TRIG;
      halt_r <= RST_RTS_HALT;
    end
    else if (i_bus.wr)
    begin
      case (i_bus.addr)
        OFS_MODEM_CTRL: mcr_r  <= i_bus.wdata;
        OFS_INT_MASK:   mask_r <= i_bus.wdata;
        OFS_TX_TRIG:    trig_r <= i_bus.wdata;
        OFS_RTS_HALT:   halt_r <= i_bus.wdata;
        default:        mcr_r  <= mcr_r;
      endcase
    end
  // ======
  // Checks
  // ======
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  chk_ring_level: assert property (msr_rd |=>
    o_rd_data[MSR_RING_BIT] == $past(i_ring_indicator_in)) else $error("ring bit wrong");
  chk_trail_set: assert property ($rose(i_ring_indicator_in) ##1 !msr_rd ##1 msr_rd
    |=> o_rd_data[MSR_TRAIL_BIT]) else $error("edge flag missing");
  chk_ring_irq: assert property ($rose(i_ring_indicator_in) && mask_r[EV_RING_BIT]
    |=> o_irq) else $error("ring irq missing");
  chk_rts_manual: assert property (!mcr_r[MCR_LOOP_BIT] && !mcr_r[MCR_AUTO_RTS_BIT]
    |=> o_rts_n == !$past(mcr_r[MCR_RTS_BIT])) else $error("rts not following control");
  chk_loop_idle: assert property (mcr_r[MCR_LOOP_BIT] |=> o_rts_n && o_tx_pin)
    else $error("loop pins not idle");
  chk_rts_auto: assert property ((mcr_r[MCR_AUTO_RTS_BIT]
    && i_rx_stat.level >= halt_r)[*2] |=> o_rts_n) else $error("auto rts not halted");
  chk_loop_route: assert property (mcr_r[MCR_LOOP_BIT]
    |=> o_rx_serial == $past(i_tx_serial)) else $error("loop route wrong");
  chk_rx_set: assert property ((i_rx_stat.trig_reached || i_rx_stat.timeout)
    && !(i_rx_stat.fifo_empty || i_rx_stat.fifo_err) |=> !o_rx_ready_n) else $error("rx low");
  chk_rx_clr: assert property (i_rx_stat.fifo_empty || i_rx_stat.fifo_err
    |=> o_rx_ready_n) else $error("rx ready not high");
  chk_tx_set: assert property (!i_tx_stat.full && i_tx_stat.free_cnt >= trig_r
    |=> !o_tx_ready_n) else $error("tx ready not low");
  chk_tx_clr: assert property (i_tx_stat.full |=> o_tx_ready_n)
    else $error("tx ready not high");
  cov_ring: cover property ($rose(i_ring_indicator_in) && mask_r[EV_RING_BIT]);
  cov_loop: cover property (mcr_r[MCR_LOOP_BIT]);
  cov_auto: cover property (mcr_r[MCR_AUTO_RTS_BIT] && i_rx_stat.level >= halt_r);
endmodule

bind ump_modem_pins ump_modem_pins_monitor #(.P_DATA_W(P_DATA_W)) mon (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rd_data(o_rd_data),
  .i_ring_indicator_in(i_ring_indicator_in), .i_rx_pin(i_rx_pin), .o_tx_pin(o_tx_pin),
  .o_rts_n(o_rts_n), .i_tx_serial(i_tx_serial), .o_rx_serial(o_rx_serial),
  .i_rx_stat(i_rx_stat), .i_tx_stat(i_tx_stat), .o_rx_ready_n(o_rx_ready_n),
  .o_tx_ready_n(o_tx_ready_n), .o_irq(o_irq));

// *** bench/ump_modem_peer.sv ***
`timescale 1ns/1ps
module ump_modem_peer
(
  // Clock
  input  wire logic i_core_clk,
  // Modem lines
  output logic      o_ring,
  output logic      o_rx
);
  // ======
  // Line drivers
  // ======
  // idle line high
  initial
  begin
    o_ring = 1'b0;
    o_rx   = 1'b1;
  end
  // Callers return the receive line high when done, as an idle modem would.
  task automatic drive(input logic ring_v, input logic rx_v);
    @(posedge i_core_clk);
    o_ring <= ring_v;
    o_rx   <= rx_v;
  endtask
endmodule

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb
  import ump_pkg::*;
();
  logic              i_core_clk, i_rst, i_tx_serial;
  ump_bus_req_t      bus;
  ump_rx_stat_t      rxs;
  ump_tx_stat_t      txs;
  logic [DATA_W-1:0] rd_data;
  logic              ring, rx_pin, tx_pin, rts_n, rx_ser, rx_rdy_n, tx_rdy_n, irq;
  int                n_fail, n_checks, cyc;
  logic [DATA_W-1:0] rst_val [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h60, 8'h20, 8'h07};
  logic [DATA_W-1:0] lv [4] = '{8'h60, 8'h30, 8'h20, 8'h5F};
  logic              ex [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

  ump_modem_pins uut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_bus(bus), .o_rd_data(rd_data),
    .i_ring_indicator_in(ring), .i_rx_pin(rx_pin), .o_tx_pin(tx_pin), .o_rts_n(rts_n),
    .i_tx_serial(i_tx_serial), .o_rx_serial(rx_ser), .i_rx_stat(rxs), .i_tx_stat(txs),
    .o_rx_ready_n(rx_rdy_n), .o_tx_ready_n(tx_rdy_n), .o_irq(irq));
  ump_modem_peer peer (.i_core_clk(i_core_clk), .o_ring(ring), .o_rx(rx_pin));

  // ======
  // Clock, timeout and tasks
  // ======
  always #50 i_core_clk = ~i_core_clk;
  // The whole sequence needs about 120 cycles; the ceiling at 3000 leaves wide margin.
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      results();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge i_core_clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge i_core_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic chk8(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge i_core_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_core_clk);
    bus.rd <= 1'b0;
    @(negedge i_core_clk);
    n_checks++;
    if (rd_data !== e)
    begin
      n_fail++;
      $display("ERROR t=%0t reg %h got %h exp %h", $time, a, rd_data, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR t=%0t pin got %h exp %h", $time, g, e);
    end
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ======
  // Sequence
  // ======
  initial
  begin
    i_core_clk = 1'b0;
    i_rst = 1'b1;
    i_tx_serial = 1'b1;
    bus = '0;
    rxs = '{1'b0, 1'b0, 1'b1, 1'b0, 8'h00};
    txs = '0;
    repeat (20) @(posedge i_core_clk);
    i_rst <= 1'b0;
    chk1(rts_n, 1'b1);
    chk1(irq, 1'b0);
    for (int i = 0; i < 8; i++)
      chk8(3'(i), rst_val[i]);
    wr(OFS_INT_MASK, 8'h01);
    peer.drive(1'b1, 1'b1);
    tick(2);
    chk1(irq, 1'b1);
    chk8(OFS_MODEM_STAT, 8'h44);
    chk8(OFS_MODEM_STAT, 8'h40);
    chk8(OFS_INT_STAT, 8'h01);
    wr(OFS_INT_STAT, 8'h01);
    tick(2);
    chk1(irq, 1'b0);
    wr(OFS_INT_MASK, 8'h00);
    peer.drive(1'b0, 1'b1);
    peer.drive(1'b1, 1'b1);
    peer.drive(1'b0, 1'b1);
    tick(2);
    chk1(irq, 1'b0);
    chk8(OFS_MODEM_STAT, 8'h04);
    wr(OFS_INT_STAT, 8'h01);
    peer.drive(1'b0, 1'b0);
    @(posedge i_core_clk);
    i_tx_serial <= 1'b0;
    tick(2);
    chk1(rx_ser, 1'b0);
    chk1(tx_pin, 1'b0);
    wr(OFS_MODEM_CTRL, 8'h12);
    @(posedge i_core_clk);
    i_tx_serial <= 1'b1;
    tick(2);
    chk1(rts_n, 1'b1);
    chk1(rx_ser, 1'b1);
    chk1(tx_pin, 1'b1);
    @(posedge i_core_clk);
    i_tx_serial <= 1'b0;
    peer.drive(1'b0, 1'b1);
    tick(2);
    chk1(tx_pin, 1'b1);
    chk1(rx_ser, 1'b0);
    wr(OFS_MODEM_CTRL, 8'h02);
    peer.drive(1'b0, 1'b1);
    tick(2);
    chk1(rts_n, 1'b0);
    wr(OFS_MODEM_CTRL, 8'h00);
    tick(2);
    chk1(rts_n, 1'b1);
    wr(OFS_MODEM_CTRL, 8'h22);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge i_core_clk);
      rxs.level <= lv[i];
      tick(3);
      chk1(rts_n, ex[i]);
    end
    wr(OFS_MODEM_CTRL, 8'h00);
    wr(OFS_INT_MASK, 8'h06);
    @(posedge i_core_clk);
    rxs <= '{1'b1, 1'b0, 1'b0, 1'b0, 8'h10};
    tick(2);
    chk1(rx_rdy_n, 1'b0);
    chk1(irq, 1'b1);
    @(posedge i_core_clk);
    rxs.trig_reached <= 1'b0;
    tick(2);
    chk1(rx_rdy_n, 1'b0);
    @(posedge i_core_clk);
    rxs.fifo_err <= 1'b1;
    tick(2);
    chk1(rx_rdy_n, 1'b1);
    @(posedge i_core_clk);
    rxs <= '{1'b0, 1'b1, 1'b0, 1'b0, 8'h01};
    tick(2);
    chk1(rx_rdy_n, 1'b0);
    @(posedge i_core_clk);
    rxs <= '{1'b1, 1'b0, 1'b1, 1'b0, 8'h00};
    tick(2);
    chk1(rx_rdy_n, 1'b1);
    @(posedge i_core_clk);
    txs <= '{1'b0, 8'h0F};
    tick(2);
    chk1(tx_rdy_n, 1'b1);
    @(posedge i_core_clk);
    txs.free_cnt <= 8'h10;
    tick(2);
    chk1(tx_rdy_n, 1'b0);
    chk8(OFS_PIN_STAT, 8'h05);
    @(posedge i_core_clk);
    txs.full <= 1'b1;
    tick(2);
    chk1(tx_rdy_n, 1'b1);
    chk8(OFS_INT_STAT, 8'h06);
    wr(OFS_INT_STAT, 8'h06);
    tick(2);
    chk1(irq, 1'b0);
    results();
  end
endmodule
